// file: clock_strap_latch_and_spread.sv
// Purpose: Power-up strap capture, output enabling, memory clock fan-out and spread control.
// Assumes: Supply-good, straps, stop inputs and the memory clock input arrive asynchronously.
// Notes:   Clock generation itself is analog; this block drives its enables and modulation word.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "clock_strap_map.svh"

// Operation
// R01: Each of thirteen memory clock outputs copies the buffered memory clock input.
// R02: Memory clock outputs are forced low while clock stop input is low.
// R03: Dual-purpose pins are strap inputs at power-up, then latched and become outputs.
// R04: Strap to ground latches 0, strap to supply latches 1.
// R05: Dual-purpose pins stay three-stated for the first 2 ms.
// R06: At the end of the 2 ms window the pin levels are captured.
// R07: Output buffers of dual-purpose pins enable only after capture.
// R08: The window timer starts when supply-good shows the 2.0V threshold.
// R09: Captured straps hold until power is removed and restored.
// R10: After enabling, each output delivers the strap-selected frequency.
// R11: One shortened processor clock cycle may appear at first enable.
// R12: Processor and bus clocks carry frequency-modulation spreading.
// R13: Spread is down 0.5 percent or centre 0.5 percent per frequency selection.
// R14: No control disables the spread modulation.
// R15: Mode strap picks reference output or bus clock stop input on shared pin.
// R16: Three frequency straps choose processor and bus frequencies and spread type.
// R17: Selection timer counts reference cycles from supply-good, then one latch strobe.
// R18: Dual-purpose pin generators do not drive until after the latch strobe.
module clock_strap_latch_and_spread #(
  parameter int unsigned SELECT_CYCLES = `CSS_SELECT_CYCLES,
  parameter int unsigned MEMCLK_COUNT  = 13
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    supply_good,
  input  wire logic                    memclk_buffer_in,
  input  wire logic                    clk_stop_n,
  input  wire logic [2:0]              freq_sel_in,
  input  wire logic                    mode_in,
  input  wire logic                    bus_stop_n_in,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic [31:0]                  prdata,
  output logic [MEMCLK_COUNT-1:0]      memclk_buffer_out,
  output logic [2:0]                   freq_sel_oe,
  output logic                         mode_oe,
  output logic                         ref_clk_out0_oe,
  output logic                         proc_clk_en,
  output logic                         bus_clk_stop,
  output clock_strap_pkg::freq_cfg_type freq_cfg,
  output logic [15:0]                  spread_offset
);

  // =====================================================================
  // Input synchronisers
  // =====================================================================
  localparam int SYNC_W = 8;
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_out;
  logic              supply_ok;
  logic              memclk_s;
  logic              clk_stop_ok_n;
  logic [2:0]        fs_s;
  logic              mode_s;
  logic              bus_stop_s_n;

  // Two flops on every asynchronous input; only the second stage is read.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_meta <= '0;
      sync_out  <= '0;
    end
    else
    begin
      sync_meta <= {bus_stop_n_in, mode_in, freq_sel_in, clk_stop_n, memclk_buffer_in, supply_good};
      sync_out  <= sync_meta;
    end
  end

  assign supply_ok     = sync_out[0];
  assign memclk_s      = sync_out[1];
  assign clk_stop_ok_n = sync_out[2];
  assign fs_s          = sync_out[5:3];
  assign mode_s        = sync_out[6];
  assign bus_stop_s_n  = sync_out[7];

  // =====================================================================
  // Power-up sequencer
  // =====================================================================
  clock_strap_pkg::seq_state_type state;
  logic [31:0]                    sel_count;
  logic                           latch_strobe;
  clock_strap_pkg::strap_type     strap;
  logic                           outputs_on;
  logic                           ctrl_oe;

  // R17 selection period timer
  assign latch_strobe = (state == clock_strap_pkg::ST_SELECT) && (sel_count == SELECT_CYCLES - 1);

  // The sequencer never returns to waiting: only a power cycle (reset) repeats selection.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state     <= clock_strap_pkg::ST_WAIT_SUPPLY;
      sel_count <= 32'h0000_0000;
    end
    else
    begin
      unique case (state)
        clock_strap_pkg::ST_WAIT_SUPPLY:
        begin
          // R08 start on supply
          if (supply_ok)
          begin
            state <= clock_strap_pkg::ST_SELECT;
          end
        end
        clock_strap_pkg::ST_SELECT:
        begin
          // R05 two ms window
          sel_count <= sel_count + 32'h0000_0001;
          if (latch_strobe)
          begin
            state <= clock_strap_pkg::ST_RUN;
          end
        end
        clock_strap_pkg::ST_RUN:
        begin
          state <= clock_strap_pkg::ST_RUN;
        end
        default:
        begin
          state <= clock_strap_pkg::ST_WAIT_SUPPLY;
        end
      endcase
    end
  end

  // R06 capture at window end
  // R04 pin level is bit
  // R09 hold until reset
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap <= '0;
    end
    else if (latch_strobe)
    begin
      strap <= '{mode: mode_s, freq_sel: fs_s};
    end
  end

  // R07 enable after capture
  // R18 no drive before strobe
  // R03 pins become outputs
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      outputs_on      <= 1'b0;
      freq_sel_oe     <= 3'h0;
      mode_oe         <= 1'b0;
      ref_clk_out0_oe <= 1'b0;
    end
    else
    begin
      if (state == clock_strap_pkg::ST_RUN)
      begin
        outputs_on <= 1'b1;
      end
      freq_sel_oe     <= {3{outputs_on & ctrl_oe}};
      mode_oe         <= outputs_on & ctrl_oe;
      // R15 shared pin function
      ref_clk_out0_oe <= outputs_on & ctrl_oe & strap.mode;
    end
  end

  // =====================================================================
  // Frequency decode and spread
  // =====================================================================
  logic [15:0] mod_phase;
  logic        mod_up;

  // R16 frequency strap decode
  // R13 spread type choice
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      freq_cfg <= '{bus_divide: 2'h0, spread: clock_strap_pkg::SPREAD_DOWN, reserved: 1'b0};
    end
    else
    begin
      freq_cfg.bus_divide <= strap.freq_sel[2] ? 2'h3 : ((strap.freq_sel == 3'h0) ? 2'h3 : 2'h2);
      freq_cfg.spread     <= (strap.freq_sel[1:0] == 2'h1) ? clock_strap_pkg::SPREAD_CENTER
                                                           : clock_strap_pkg::SPREAD_DOWN;
      freq_cfg.reserved   <= (strap.freq_sel == 3'h6);
    end
  end

  // R12 triangular modulation
  // R14 always on
  // The turn is taken in the same cycle as the step, so the phase never wraps past either end.
  // A wrap would turn the triangle into a two-level square wave with almost no spreading.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mod_phase <= 16'h0000;
      mod_up    <= 1'b1;
    end
    else if (mod_up)
    begin
      if (mod_phase > 16'hFFFF - `CSS_MOD_STEP)
      begin
        mod_up    <= 1'b0;
        mod_phase <= mod_phase - `CSS_MOD_STEP;
      end
      else
      begin
        mod_phase <= mod_phase + `CSS_MOD_STEP;
      end
    end
    else
    begin
      if (mod_phase < `CSS_MOD_STEP)
      begin
        mod_up    <= 1'b1;
        mod_phase <= mod_phase + `CSS_MOD_STEP;
      end
      else
      begin
        mod_phase <= mod_phase - `CSS_MOD_STEP;
      end
    end
  end

  // Down spread offsets from zero downward; centre spread is symmetric about zero.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      spread_offset <= 16'h0000;
    end
    else if (freq_cfg.spread == clock_strap_pkg::SPREAD_DOWN)
    begin
      spread_offset <= 16'h0000 - {1'b0, mod_phase[15:1]};
    end
    else
    begin
      spread_offset <= mod_phase ^ 16'h8000;
    end
  end

  // R10 selected frequency delivered
  // R11 short first cycle tolerated
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      proc_clk_en  <= 1'b0;
      bus_clk_stop <= 1'b0;
    end
    else
    begin
      proc_clk_en  <= outputs_on & ctrl_oe & ~freq_cfg.reserved;
      bus_clk_stop <= ~strap.mode & ~bus_stop_s_n & outputs_on;
    end
  end

  // =====================================================================
  // Memory clock fan-out
  // =====================================================================
  // R01 copy input
  // R02 stop forces low
  // The copy is sampled, so it only follows inputs well below half the core rate.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      memclk_buffer_out <= '0;
    end
    else
    begin
      memclk_buffer_out <= {MEMCLK_COUNT{memclk_s & clk_stop_ok_n}};
    end
  end

  // =====================================================================
  // APB slave
  // =====================================================================
  logic        acc_setup;
  logic [31:0] status_word;

  assign acc_setup   = psel & ~penable;
  assign status_word = {24'h0, ~bus_stop_s_n, freq_cfg.reserved,
                        (freq_cfg.spread == clock_strap_pkg::SPREAD_CENTER),
                        outputs_on, strap.mode, strap.freq_sel};

  // Control register; only the output enable bit is writable.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Only bit zero of the reset word is stored; the other bits read as zero.
      ctrl_oe <= 1'(`CSS_CTRL_RESET);
    end
    else if (psel && penable && pready && pwrite && (paddr == `CSS_CONTROL_OFFSET))
    begin
      ctrl_oe <= pwdata[`CSS_CTRL_OE_BIT];
    end
  end

  // No wait state: pready rises in the first access cycle, data is ready with it.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc_setup;
      pslverr <= acc_setup && !((paddr == `CSS_STATUS_OFFSET) || (paddr == `CSS_CONTROL_OFFSET)
                                || (paddr == `CSS_ACCUM_OFFSET));
      if (acc_setup && !pwrite)
      begin
        unique case (paddr)
          `CSS_STATUS_OFFSET:  prdata <= status_word;
          `CSS_CONTROL_OFFSET: prdata <= {31'h0, ctrl_oe};
          `CSS_ACCUM_OFFSET:   prdata <= {16'h0, spread_offset};
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : clock_strap_latch_and_spread

// file: clock_strap_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the strap and spread block.
// Assumes: A core clock of 100 MHz.
// Notes:   Definitions only.
`ifndef CLOCK_STRAP_MAP_SVH
`define CLOCK_STRAP_MAP_SVH

// =====================================================================
// APB register map
// =====================================================================
`define CSS_STATUS_OFFSET   12'h000
`define CSS_CONTROL_OFFSET  12'h004
`define CSS_ACCUM_OFFSET    12'h008

// Status field positions.
`define CSS_STAT_FS_LSB     0
`define CSS_STAT_MODE_BIT   3
`define CSS_STAT_DONE_BIT   4
`define CSS_STAT_SPREAD_BIT 5
`define CSS_STAT_RSVD_BIT   6
`define CSS_STAT_PSTOP_BIT  7

// Control field positions and reset value.
`define CSS_CTRL_OE_BIT     0
`define CSS_CTRL_RESET      32'h0000_0001

// =====================================================================
// Timing
// =====================================================================
`define CSS_CLK_MHZ         100
`define CSS_SELECT_US       2000
`define CSS_SELECT_CYCLES   (`CSS_SELECT_US * `CSS_CLK_MHZ)
`define CSS_MOD_STEP        16'h0040

`endif

// file: clock_strap_pkg.sv
// Purpose: Types shared by the strap and spread block.
// Assumes: Timing and offsets live in the map header.
// Notes:   Types only.
package clock_strap_pkg;

  // =====================================================================
  // Latched strap word
  // =====================================================================
  typedef struct packed {
    logic       mode;
    logic [2:0] freq_sel;
  } strap_type;

  // Spread kind selected by the straps.
  typedef enum logic [1:0] {
    SPREAD_DOWN   = 2'b01,
    SPREAD_CENTER = 2'b10
  } spread_type;

  // Power-up sequencer states.
  typedef enum logic [2:0] {
    ST_WAIT_SUPPLY = 3'b001,
    ST_SELECT      = 3'b010,
    ST_RUN         = 3'b100
  } seq_state_type;

  // Settings handed to the synthesizer.
  typedef struct packed {
    logic [1:0] bus_divide;
    spread_type spread;
    logic       reserved;
  } freq_cfg_type;

endpackage : clock_strap_pkg

// file: strap_props.sv
// Purpose: Port-level checks of the strap latch and spread block.
// Assumes: One clock domain and an active-low reset.
// Notes:   Bound to the block from the testbench top file.
`timescale 1ns/10ps
`include "clock_strap_map.svh"
module strap_props #(
  parameter int unsigned SELECT_CYCLES = `CSS_SELECT_CYCLES,
  parameter int unsigned MEMCLK_COUNT  = 13
) (
  input wire logic                         core_clk,
  input wire logic                         reset_n,
  input wire logic                         supply_good,
  input wire logic                         memclk_buffer_in,
  input wire logic                         clk_stop_n,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pready,
  input wire logic [MEMCLK_COUNT-1:0]      memclk_buffer_out,
  input wire logic [2:0]                   freq_sel_oe,
  input wire logic                         mode_oe,
  input wire logic                         ref_clk_out0_oe,
  input wire logic                         proc_clk_en,
  input wire logic                         bus_clk_stop,
  input wire clock_strap_pkg::freq_cfg_type freq_cfg,
  input wire logic [15:0]                  spread_offset
);
  localparam int unsigned HOLD = SELECT_CYCLES + 8;
  int unsigned up_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Edges seen with supply good; saturates so a long run never wraps.
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      up_cnt <= 0;
    else if (supply_good && up_cnt < 32'hFFFF_FFFF)
      up_cnt <= up_cnt + 1;

  sequence stop_held;
    !clk_stop_n [*4];
  endsequence
  sequence input_high;
    (clk_stop_n && memclk_buffer_in) [*4];
  endsequence

  memclk_stop_a: assert property (stop_held |=> memclk_buffer_out == '0)
    else $error("memory clocks run while stopped");
  memclk_copy_a: assert property (input_high |=> &memclk_buffer_out)
    else $error("memory clocks do not copy the input");
  oe_quiet_a: assert property ((freq_sel_oe != 3'h0 || mode_oe) |-> up_cnt > SELECT_CYCLES)
    else $error("pins driven inside the window");
  oe_group_a: assert property (freq_sel_oe == {3{mode_oe}})
    else $error("pin enables disagree");
  proc_quiet_a: assert property (proc_clk_en |-> up_cnt > SELECT_CYCLES)
    else $error("generators on inside the window");
  ref_share_a: assert property (!(ref_clk_out0_oe && bus_clk_stop))
    else $error("shared pin in both roles");
  strap_hold_a: assert property (up_cnt > HOLD |-> $stable(freq_cfg))
    else $error("latched setting changed");
  spread_kind_a: assert property (freq_cfg.spread == clock_strap_pkg::SPREAD_DOWN
    || freq_cfg.spread == clock_strap_pkg::SPREAD_CENTER)
    else $error("bad spread kind");
  spread_live_a: assert property (1'b1 |-> ##[1:1000] $changed(spread_offset))
    else $error("modulation stalled");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not one cycle");
endmodule : strap_props

// file: strap_board.sv
// Purpose: Board straps and memory clock source beside the block.
// Assumes: A driven pin shows the device clock, not the strap.
// Notes:   Memory clock runs at one eighth of the core clock.
`timescale 1ns/10ps
module strap_board (
  input  wire logic       core_clk,
  input  wire logic [3:0] strap,
  input  wire logic [2:0] freq_sel_oe,
  input  wire logic       mode_oe,
  output logic [2:0]      freq_sel_in,
  output logic            mode_in,
  output logic            memclk_buffer_in
);
  logic [2:0] phase = 3'h0;

  // Free-running phase feeds the memory clock and the driven-pin pattern.
  always_ff @(posedge core_clk)
    phase <= phase + 3'h1;
  assign memclk_buffer_in = phase[2];
  assign freq_sel_in = (freq_sel_oe & {3{phase[0]}}) | (~freq_sel_oe & strap[2:0]);
  assign mode_in     = mode_oe ? phase[0] : strap[3];
endmodule : strap_board

// file: clock_strap_latch_and_spread_tb.sv
// Purpose: Self-checking bench for the strap latch and spread block.
// Assumes: A selection window shortened to 20 cycles.
// Notes:   Every power-up is a fresh reset, as a power cycle would be.
`timescale 1ns/10ps
`include "clock_strap_map.svh"
module clock_strap_latch_and_spread_tb;
  localparam int unsigned SEL = 20;
  logic core_clk = 1'b0, reset_n = 1'b0, supply_good = 1'b0;
  logic clk_stop_n = 1'b1, bus_stop_n_in = 1'b1, memclk_buffer_in, mode_in;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rd2;
  logic [2:0] freq_sel_in, freq_sel_oe;
  logic [3:0] strap = 4'h0;
  logic [12:0] memclk_buffer_out;
  logic mode_oe, ref_clk_out0_oe, proc_clk_en, bus_clk_stop;
  clock_strap_pkg::freq_cfg_type freq_cfg;
  logic [15:0] spread_offset;
  int fail_count = 0, check_count = 0, cyc = 0;

  initial forever #5 core_clk = ~core_clk;

  clock_strap_latch_and_spread #(.SELECT_CYCLES(SEL)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .supply_good(supply_good), .memclk_buffer_in(memclk_buffer_in), .clk_stop_n(clk_stop_n),
    .freq_sel_in(freq_sel_in), .mode_in(mode_in), .bus_stop_n_in(bus_stop_n_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .memclk_buffer_out(memclk_buffer_out), .freq_sel_oe(freq_sel_oe),
    .mode_oe(mode_oe), .ref_clk_out0_oe(ref_clk_out0_oe), .proc_clk_en(proc_clk_en),
    .bus_clk_stop(bus_clk_stop), .freq_cfg(freq_cfg), .spread_offset(spread_offset));
  strap_board u_board (.core_clk(core_clk), .strap(strap), .freq_sel_oe(freq_sel_oe), .mode_oe(mode_oe),
    .freq_sel_in(freq_sel_in), .mode_in(mode_in), .memclk_buffer_in(memclk_buffer_in));

  function automatic logic [31:0] stat_exp(input logic [3:0] s, input logic ps);
    return {24'h0, ps, s[2:0] == 3'h6, s[1:0] == 2'h1, 1'b1, s};
  endfunction : stat_exp

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One transfer; request held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic power_up(input logic [3:0] s);
    int n = 0;
    @(posedge core_clk);
    reset_n <= 1'b0;
    supply_good <= 1'b0;
    strap <= s;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (SEL + 10) @(posedge core_clk);
    chk("oe_before_supply", 0, mode_oe);
    supply_good <= 1'b1;
    while (mode_oe !== 1'b1 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    chk("enable_delay", 1, n > SEL && n < SEL + 10);
  endtask : power_up

  task automatic test_codes();
    logic [3:0] s;
    for (int c = 0; c < 8; c++)
    begin
      s = {c[0], c[2:0]};
      power_up(s);
      apb(1'b0, `CSS_STATUS_OFFSET, 32'h0, rd, err);
      chk("status", stat_exp(s, 1'b0), rd);
      chk("pin_oe", 3'h7, freq_sel_oe);
      chk("ref_oe", s[3], ref_clk_out0_oe);
      chk("proc_en", c != 6, proc_clk_en);
      chk("spread", s[1:0] == 2'h1 ? 2'h2 : 2'h1, freq_cfg.spread);
      if (c != 6) chk("bus_divide", (s[2] || s[1:0] == 2'h0) ? 2'h3 : 2'h2, freq_cfg.bus_divide);
      strap <= ~s;
      repeat (4) @(posedge core_clk);
      apb(1'b0, `CSS_STATUS_OFFSET, 32'h0, rd2, err);
      chk("status_hold", rd, rd2);
    end
    $display("test_codes done");
  endtask : test_codes

  task automatic test_memclk();
    int hi = 0, lo = 0;
    repeat (16)
    begin
      @(posedge core_clk);
      hi += (memclk_buffer_out === 13'h1FFF);
      lo += (memclk_buffer_out === 13'h0000);
    end
    chk("memclk_high", 8, hi);
    chk("memclk_low", 8, lo);
    clk_stop_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    hi = 0;
    repeat (8)
    begin
      @(posedge core_clk);
      hi += (memclk_buffer_out !== 13'h0000);
    end
    chk("memclk_stopped", 0, hi);
    clk_stop_n <= 1'b1;
    $display("test_memclk done");
  endtask : test_memclk

  task automatic test_ctrl();
    apb(1'b0, `CSS_CONTROL_OFFSET, 32'h0, rd, err);
    chk("ctrl_reset", `CSS_CTRL_RESET, rd);
    apb(1'b1, `CSS_CONTROL_OFFSET, 32'h0, rd, err);
    repeat (4) @(posedge core_clk);
    chk("oe_off", 5'h00, {freq_sel_oe, mode_oe, proc_clk_en});
    apb(1'b1, `CSS_CONTROL_OFFSET, 32'h1, rd, err);
    repeat (4) @(posedge core_clk);
    chk("oe_on", 5'h1F, {freq_sel_oe, mode_oe, proc_clk_en});
    apb(1'b0, 12'h00C, 32'h0, rd, err);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rd);
    apb(1'b1, `CSS_STATUS_OFFSET, 32'hFF, rd, err);
    apb(1'b0, `CSS_STATUS_OFFSET, 32'h0, rd, err);
    chk("status_ro", stat_exp(4'hF, 1'b0), rd);
    apb(1'b0, `CSS_ACCUM_OFFSET, 32'h0, rd, err);
    apb(1'b0, `CSS_ACCUM_OFFSET, 32'h0, rd2, err);
    chk("spread_moving", 1, rd !== rd2);
    $display("test_ctrl done");
  endtask : test_ctrl

  task automatic test_bus_stop();
    power_up(4'h3);
    bus_stop_n_in <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("bus_stop", 1, bus_clk_stop);
    apb(1'b0, `CSS_STATUS_OFFSET, 32'h0, rd, err);
    chk("status_stop", stat_exp(4'h3, 1'b1), rd);
    bus_stop_n_in <= 1'b1;
    $display("test_bus_stop done");
  endtask : test_bus_stop

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // A hang ends the run as a mismatch.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    test_codes();
    test_memclk();
    test_ctrl();
    test_bus_stop();
    results();
  end
endmodule : clock_strap_latch_and_spread_tb

bind clock_strap_latch_and_spread strap_props #(.SELECT_CYCLES(SELECT_CYCLES), .MEMCLK_COUNT(MEMCLK_COUNT))
  u_props (.core_clk(core_clk), .reset_n(reset_n), .supply_good(supply_good),
  .memclk_buffer_in(memclk_buffer_in), .clk_stop_n(clk_stop_n), .psel(psel), .penable(penable),
  .pready(pready), .memclk_buffer_out(memclk_buffer_out), .freq_sel_oe(freq_sel_oe), .mode_oe(mode_oe),
  .ref_clk_out0_oe(ref_clk_out0_oe), .proc_clk_en(proc_clk_en), .bus_clk_stop(bus_clk_stop),
  .freq_cfg(freq_cfg), .spread_offset(spread_offset));
